//--- verilog/lvcs_defines.svh
// register offsets, field positions, reset values and sizes of the channel-set router
// assumes: included by bare name from the package and the design modules
`ifndef LVCS_DEFINES_SVH
`define LVCS_DEFINES_SVH

`define LVCS_ADDR_CTRL      8'h00
`define LVCS_ADDR_EN_SIDE0  8'h04
`define LVCS_ADDR_EN_SIDE1  8'h08
`define LVCS_ADDR_CAPS      8'h0C
`define LVCS_ADDR_STATUS    8'h10

`define LVCS_CTRL_W         5
`define LVCS_CTRL_RESET     5'h00
`define LVCS_EN_RESET       8'h00
`define LVCS_STAT_DROP_BIT  0
`define LVCS_STAT_ILL_BIT   1

`define LVCS_SUPPORT_DEF    8'h07
`define LVCS_STREAM_CNT_DEF 5'h10
`define LVCS_BUF_DEPTH      4
`define LVCS_BUF_FULL       3'h4
`define LVCS_LEGACY_SEQ     4'h8
`define LVCS_LEGACY_MAP     4'h1

`endif

//--- verilog/lvcs_pkg.sv
// types shared by the channel-set router and its per-class buffers
// assumes: lvcs_defines.svh is on the include path
`include "lvcs_defines.svh"

package lvcs_pkg;

  // traffic class of a packet, as carried in its command
  typedef enum logic [1:0] {
    LVCS_CLS_POSTED    = 2'b00,
    LVCS_CLS_NONPOSTED = 2'b01,
    LVCS_CLS_RESPONSE  = 2'b10,
    LVCS_CLS_INFO      = 2'b11
  } lvcs_class_t;

  // channel set codes 0..7 plus the two sets named by the isoc bit alone
  typedef enum logic [3:0] {
    LVCS_SET_ALT      = 4'b0000,
    LVCS_SET_UNFLOWED = 4'b0001,
    LVCS_SET_STREAM   = 4'b0010,
    LVCS_SET_RSV3     = 4'b0011,
    LVCS_SET_IMP4     = 4'b0100,
    LVCS_SET_RSV5     = 4'b0101,
    LVCS_SET_IMP6     = 4'b0110,
    LVCS_SET_IMP7     = 4'b0111,
    LVCS_SET_BASE     = 4'b1000,
    LVCS_SET_ISOC     = 4'b1001
  } lvcs_set_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lvcs_reg_req_t;

  // received non-info packet header fields used for classification
  typedef struct packed {
    logic        side;
    lvcs_class_t cls;
    logic        isoc;
    logic [3:0]  sequence_tag;
    logic [4:0]  source_tag_field;
    logic [2:0]  response_set_field;
    logic        pass_posted_write_flag;
  } lvcs_pkt_t;

  // classified packet handed to the forwarding side
  typedef struct packed {
    lvcs_set_t   set;
    logic [3:0]  channel;
    lvcs_class_t cls;
    logic [3:0]  sequence_tag;
    logic [4:0]  source_tag_field;
    logic        pass_posted_write_flag;
    logic        out_side;
    logic        end_of_chain;
    logic        reflect;
  } lvcs_fwd_t;

  typedef struct packed {
    logic [1:0] isoc_flow_en;
    logic       host_couple_en;
    logic       host_slave_mode_bit;
    logic       is_host;
  } lvcs_ctrl_t;

  typedef struct packed {
    lvcs_ctrl_t  ctrl;
    logic [7:0]  side0_channel_set_enables;
    logic [7:0]  side1_channel_set_enables;
    logic        dropped;
    logic        illegal;
    logic [31:0] rdata;
    logic [2:0]  rx_ready;
    logic        side0_legacy;
    logic        side1_legacy;
  } lvcs_top_state_t;

  typedef struct packed {
    lvcs_fwd_t [`LVCS_BUF_DEPTH-1:0] mem;
    logic [2:0]                      count;
    logic                            nonempty;
  } lvcs_buf_state_t;

endpackage : lvcs_pkg

//--- verilog/lvcs_chan_buf.sv
// per-class packet buffer: a short shift queue whose head is a flip-flop
// assumes: caller never pushes when room_next was low in the cycle before
`timescale 1ns/10ps
`default_nettype none
`include "lvcs_defines.svh"

module lvcs_chan_buf
  import lvcs_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      reset,
  input  wire logic      ce,
  input  wire logic      push,
  input  wire lvcs_fwd_t push_data,
  input  wire logic      pop,
  output lvcs_fwd_t      head,
  output logic           head_valid,
  output logic           room_next
);

  lvcs_buf_state_t s_q;
  lvcs_buf_state_t s_d;

  // pop shifts the queue down, push appends behind the last entry
  always_comb
  begin
    s_d = s_q;
    if (pop && s_q.count != 3'h0)
    begin
      for (int i = 0; i < `LVCS_BUF_DEPTH - 1; i++)
        s_d.mem[i] = s_q.mem[i+1];
      s_d.count = s_q.count - 3'h1;
    end
    if (push && s_d.count != `LVCS_BUF_FULL)
    begin
      s_d.mem[s_d.count[1:0]] = push_data;
      s_d.count = s_d.count + 3'h1;
    end
    s_d.nonempty = (s_d.count != 3'h0);
    room_next    = (s_d.count != `LVCS_BUF_FULL);
  end

  // ce low freezes the whole queue
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

  assign head       = s_q.mem[0];
  assign head_valid = s_q.nonempty;

endmodule : lvcs_chan_buf
`default_nettype wire

//--- verilog/lvcs_router.sv
// channel-set classifier and per-class forwarding buffers of a packet link node
// assumes: one clock, synchronous inputs, link framing and flow control done outside
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "lvcs_defines.svh"

module lvcs_router
  import lvcs_pkg::*;
#(
  parameter logic [7:0] CHANNEL_SET_SUPPORT = `LVCS_SUPPORT_DEF,
  parameter logic [4:0] STREAM_COUNT        = `LVCS_STREAM_CNT_DEF
)
(
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic            ce,
  input  wire lvcs_reg_req_t   reg_req,
  output logic [31:0]          reg_rdata,
  input  wire logic            rx_valid,
  input  wire lvcs_pkt_t       rx_pkt,
  output logic [2:0]           rx_ready,
  output logic [2:0]           tx_valid,
  output lvcs_fwd_t [2:0]      tx_data,
  input  wire logic [2:0]      tx_ready,
  output logic                 side0_legacy,
  output logic                 side1_legacy,
  output logic                 dropped_flag,
  output logic                 illegal_flag
);

  lvcs_top_state_t s_q;
  lvcs_top_state_t s_d;

  logic      [2:0] push;
  logic      [2:0] pop;
  logic      [2:0] room_next;
  lvcs_fwd_t       fwd;
  logic            bad;
  logic            take;
  logic            drop;
  logic            host_couple;

  // classification of the presented packet, ahead of any buffer choice
  always_comb
  begin
    logic [7:0] en_in;
    logic [7:0] en_out;
    logic       legacy_in;
    logic [3:0] seq;
    en_in     = rx_pkt.side ? s_q.side1_channel_set_enables : s_q.side0_channel_set_enables;
    en_out    = rx_pkt.side ? s_q.side0_channel_set_enables : s_q.side1_channel_set_enables;
    legacy_in = (en_in == 8'h00);
    seq       = rx_pkt.sequence_tag;
    fwd       = '0;
    fwd.set   = LVCS_SET_BASE;
    if (!rx_pkt.isoc)
      fwd.set = LVCS_SET_BASE;
    else if (s_q.ctrl.isoc_flow_en[rx_pkt.side])
      fwd.set = LVCS_SET_ISOC;
    else if (legacy_in)
    begin
      // legacy neighbour: isoc traffic rides the alternate set if we may send it there
      if (en_out[0])
      begin
        fwd.set = LVCS_SET_ALT;
        seq     = (seq == `LVCS_LEGACY_SEQ) ? `LVCS_LEGACY_MAP : {1'b0, seq[2:0]};
      end
    end
    else if (rx_pkt.cls == LVCS_CLS_RESPONSE)
      fwd.set = lvcs_set_t'({1'b0, rx_pkt.response_set_field});
    else
    begin
      case (seq)
        4'h8:    fwd.set = LVCS_SET_RSV3;
        4'h9:    fwd.set = LVCS_SET_RSV5;
        4'hA:    fwd.set = LVCS_SET_IMP6;
        4'hB:    fwd.set = LVCS_SET_IMP7;
        4'hC:    fwd.set = LVCS_SET_IMP4;
        4'hD:    fwd.set = LVCS_SET_UNFLOWED;
        4'hE:    fwd.set = LVCS_SET_STREAM;
        4'hF:    fwd.set = LVCS_SET_STREAM;
        default: fwd.set = LVCS_SET_ALT;
      endcase
    end
    fwd.cls                    = rx_pkt.cls;
    fwd.sequence_tag           = seq;
    fwd.source_tag_field       = rx_pkt.source_tag_field;
    fwd.pass_posted_write_flag = rx_pkt.pass_posted_write_flag;
    fwd.out_side               = ~rx_pkt.side;
    if (fwd.set == LVCS_SET_STREAM)
      fwd.channel = {seq[0], rx_pkt.source_tag_field[2:0]};
    // ordered as tag zero; the pass flag still passes through for reordering
    if (fwd.set == LVCS_SET_UNFLOWED || fwd.set == LVCS_SET_STREAM)
      fwd.sequence_tag = 4'h0;
    fwd.end_of_chain = !fwd.set[3] && !en_out[fwd.set[2:0]];
    fwd.reflect      = s_q.ctrl.is_host && !s_q.ctrl.host_slave_mode_bit &&
                       rx_pkt.cls != LVCS_CLS_RESPONSE;
    // reserved codes, unsupported codes and wrong types are refused and flagged
    bad = 1'b0;
    if (fwd.set == LVCS_SET_RSV3 || fwd.set == LVCS_SET_RSV5)
      bad = 1'b1;
    if (!fwd.set[3] && !CHANNEL_SET_SUPPORT[fwd.set[2:0]])
      bad = 1'b1;
    if ((fwd.set == LVCS_SET_UNFLOWED || fwd.set == LVCS_SET_STREAM) && rx_pkt.cls != LVCS_CLS_POSTED)
      bad = 1'b1;
    if (fwd.set == LVCS_SET_STREAM && {1'b0, fwd.channel} >= STREAM_COUNT)
      bad = 1'b1;
  end

  // acceptance per class uses only that class's own ready flag; unflowed never waits
  always_comb
  begin
    take = 1'b0;
    if (rx_valid && rx_pkt.cls != LVCS_CLS_INFO)
      take = s_q.rx_ready[rx_pkt.cls] || fwd.set == LVCS_SET_UNFLOWED;
    drop = take && !bad && fwd.set == LVCS_SET_UNFLOWED &&
           !s_q.rx_ready[LVCS_CLS_POSTED];
    for (int c = 0; c < 3; c++)
      push[c] = take && !bad && !drop && rx_pkt.cls == lvcs_class_t'(c[1:0]);
  end

  assign host_couple = s_q.ctrl.is_host && s_q.ctrl.host_couple_en;

  // each class drains on its own ready only, so responses never wait on requests
  assign pop = tx_valid & tx_ready;

  // one buffer per class keeps the three channels from starving each other
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_class
      lvcs_chan_buf u_buf (
        .clock      (clock),
        .reset      (reset),
        .ce         (ce),
        .push       (push[g]),
        .push_data  (fwd),
        .pop        (pop[g]),
        .head       (tx_data[g]),
        .head_valid (tx_valid[g]),
        .room_next  (room_next[g])
      );
    end
  endgenerate

  // register port, ready flags, sticky status and legacy indication
  always_comb
  begin
    s_d       = s_q;
    s_d.rdata = 32'h0000_0000;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        `LVCS_ADDR_CTRL:     s_d.rdata = {27'h000_0000, s_q.ctrl};
        `LVCS_ADDR_EN_SIDE0: s_d.rdata = {24'h00_0000, s_q.side0_channel_set_enables};
        `LVCS_ADDR_EN_SIDE1: s_d.rdata = {24'h00_0000, s_q.side1_channel_set_enables};
        `LVCS_ADDR_CAPS:     s_d.rdata = {19'h0_0000, STREAM_COUNT, CHANNEL_SET_SUPPORT};
        `LVCS_ADDR_STATUS:   s_d.rdata = {30'h0000_0000, s_q.illegal, s_q.dropped};
        default:             s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        `LVCS_ADDR_CTRL:
          s_d.ctrl = lvcs_ctrl_t'(reg_req.wdata[`LVCS_CTRL_W-1:0]);
        // only supported sets can be enabled
        `LVCS_ADDR_EN_SIDE0:
          s_d.side0_channel_set_enables = reg_req.wdata[7:0] & CHANNEL_SET_SUPPORT;
        `LVCS_ADDR_EN_SIDE1:
          s_d.side1_channel_set_enables = reg_req.wdata[7:0] & CHANNEL_SET_SUPPORT;
        `LVCS_ADDR_STATUS:
        begin
          if (reg_req.wdata[`LVCS_STAT_DROP_BIT])
            s_d.dropped = 1'b0;
          if (reg_req.wdata[`LVCS_STAT_ILL_BIT])
            s_d.illegal = 1'b0;
        end
        default: ;
      endcase
    end
    // a new event in the clearing cycle wins over the clear
    if (drop)
      s_d.dropped = 1'b1;
    if (take && bad)
      s_d.illegal = 1'b1;
    s_d.side0_legacy = (s_q.side0_channel_set_enables == 8'h00);
    s_d.side1_legacy = (s_q.side1_channel_set_enables == 8'h00);
    // non-host: readiness is buffer room alone; host may add the allowed couplings
    s_d.rx_ready[0] = room_next[0] && (!host_couple || tx_ready[0]);
    s_d.rx_ready[1] = room_next[1] && (!host_couple || tx_ready[2]);
    s_d.rx_ready[2] = room_next[2] && (!host_couple || tx_ready[0] || tx_ready[2]);
  end

  // all state but the class buffers in one register; reset leaves every direction in legacy mode
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_q                           <= '0;
      s_q.ctrl                      <= `LVCS_CTRL_RESET;
      s_q.side0_channel_set_enables <= `LVCS_EN_RESET;
      s_q.side1_channel_set_enables <= `LVCS_EN_RESET;
      s_q.side0_legacy              <= 1'b1;
      s_q.side1_legacy              <= 1'b1;
    end
    else if (ce)
      s_q <= s_d;
  end

  assign reg_rdata    = s_q.rdata;
  assign rx_ready     = s_q.rx_ready;
  assign side0_legacy = s_q.side0_legacy;
  assign side1_legacy = s_q.side1_legacy;
  assign dropped_flag = s_q.dropped;
  assign illegal_flag = s_q.illegal;

  // checks on classification and acceptance
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  AST_NONHOST_POSTED: assert property (
    ce && !s_q.ctrl.is_host && room_next[0] |=> rx_ready[0])
    else $error("posted acceptance held back on a non-host node");
  AST_NONHOST_NONPOSTED: assert property (
    ce && !s_q.ctrl.is_host && room_next[1] |=> rx_ready[1])
    else $error("nonposted acceptance held back on a non-host node");
  AST_NONHOST_RESPONSE: assert property (
    ce && !s_q.ctrl.is_host && room_next[2] |=> rx_ready[2])
    else $error("response acceptance held back on a non-host node");
  AST_HOST_POSTED_COUPLE: assert property (
    ce && host_couple && tx_ready[0] && room_next[0] |=> rx_ready[0])
    else $error("host posted acceptance waits on something besides posted sending");
  AST_RESERVED_REFUSED: assert property (
    take && (fwd.set == LVCS_SET_RSV3 || fwd.set == LVCS_SET_RSV5) |-> push == 3'b000)
    else $error("reserved channel set code was buffered");
  AST_STREAM_CHANNEL: assert property (
    push[0] && fwd.set == LVCS_SET_STREAM |->
      fwd.channel == {rx_pkt.sequence_tag[0], rx_pkt.source_tag_field[2:0]} && fwd.sequence_tag == 4'h0)
    else $error("stream channel number or tag wrong");
  AST_POSTED_ONLY: assert property (
    (push[1] || push[2]) |-> fwd.set != LVCS_SET_UNFLOWED && fwd.set != LVCS_SET_STREAM)
    else $error("non-posted traffic buffered in a posted-only set");
  AST_DROP_FLAG: assert property (
    ce && drop |=> dropped_flag)
    else $error("drop left no status flag");
  AST_LEGACY_IND: assert property (
    ce && s_q.side0_channel_set_enables == 8'h00 |=> side0_legacy)
    else $error("side 0 not reported as legacy with no set enabled");
  AST_END_OF_CHAIN: assert property (
    push[0] && !fwd.set[3] && !(rx_pkt.side ? s_q.side0_channel_set_enables[fwd.set[2:0]]
                                            : s_q.side1_channel_set_enables[fwd.set[2:0]])
      |-> fwd.end_of_chain)
    else $error("traffic to a disabled set not marked end of chain");

  // classification, status and host coupling checks
  AST_CLASSIFIED_PUSH: assert property (
    take && !bad && !drop |-> $onehot(push))
    else $error("accepted packet not buffered in exactly one class");

  AST_BASE_SET: assert property (
    rx_valid && !rx_pkt.isoc |-> fwd.set == LVCS_SET_BASE && !fwd.end_of_chain)
    else $error("packet with isoc clear left the base set");

  AST_ISOC_FLOW: assert property (
    rx_valid && rx_pkt.isoc && s_q.ctrl.isoc_flow_en[rx_pkt.side] |-> fwd.set == LVCS_SET_ISOC)
    else $error("isoc flow enable did not disable the numbered sets");

  AST_ALT_TAG: assert property (
    take && fwd.set == LVCS_SET_ALT && rx_pkt.cls != LVCS_CLS_RESPONSE |-> !fwd.sequence_tag[3])
    else $error("alternate set request kept tag bit 3");

  AST_LEGACY_REMAP: assert property (
    take && fwd.set == LVCS_SET_ALT && rx_pkt.cls != LVCS_CLS_RESPONSE &&
      rx_pkt.sequence_tag == `LVCS_LEGACY_SEQ |-> fwd.sequence_tag == `LVCS_LEGACY_MAP)
    else $error("legacy tag 8 not remapped");

  AST_UNFLOWED_TAKEN: assert property (
    rx_valid && rx_pkt.cls == LVCS_CLS_POSTED && fwd.set == LVCS_SET_UNFLOWED |-> take)
    else $error("unflowed packet held off");

  AST_DROP_UNFLOWED: assert property (
    drop |-> fwd.set == LVCS_SET_UNFLOWED && push == 3'b000)
    else $error("drop outside the unflowed set");

  AST_ILLEGAL_FLAG: assert property (
    ce && take && bad |=> illegal_flag)
    else $error("refused packet left no status flag");

  AST_STREAM_LIMIT: assert property (
    push[0] && fwd.set == LVCS_SET_STREAM |-> {1'b0, fwd.channel} < STREAM_COUNT)
    else $error("stream channel above the supported count buffered");

  AST_HOST_NONPOSTED: assert property (
    ce && host_couple && tx_ready[2] && room_next[1] |=> rx_ready[1])
    else $error("host nonposted acceptance held back");

  AST_HOST_RESPONSE: assert property (
    ce && host_couple && (tx_ready[0] || tx_ready[2]) && room_next[2] |=> rx_ready[2])
    else $error("host response acceptance waits on nonposted sending");

  AST_LEGACY_SIDE1: assert property (
    ce && s_q.side1_channel_set_enables == 8'h00 |=> side1_legacy)
    else $error("side 1 not reported as legacy with no set enabled");

  AST_REFLECT: assert property (
    push[1] && s_q.ctrl.is_host && !s_q.ctrl.host_slave_mode_bit |-> fwd.reflect)
    else $error("host bridge request not marked for reflection");

  AST_NO_REFLECT: assert property (
    push != 3'b000 && !s_q.ctrl.is_host |-> !fwd.reflect)
    else $error("non-host request marked for reflection");

  COV_STREAM: cover property (push[0] && fwd.set == LVCS_SET_STREAM);
  COV_DROP:   cover property (drop);
  COV_ALT_RSP: cover property (push[2] && fwd.set == LVCS_SET_ALT);
  COV_REMAP: cover property (push[0] && fwd.set == LVCS_SET_ALT && rx_pkt.sequence_tag == `LVCS_LEGACY_SEQ);
  COV_HOST_HOLD: cover property (host_couple && rx_ready != 3'b111);

endmodule : lvcs_router
`default_nettype wire

//--- verif/lvcs_sink.sv
// far-end model: downstream sink of the three class buffers, with stall and slow modes
// assumes: one clock shared with the router, which samples tx_ready at the rising edge
`timescale 1ns/10ps
`default_nettype none

module lvcs_sink
  import lvcs_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic [2:0]      tx_valid,
  input  wire lvcs_fwd_t [2:0] tx_data,
  input  wire logic [2:0]      hold,
  input  wire logic            slow,
  output logic [2:0]           tx_ready,
  output logic [7:0]           pops0,
  output logic                 bad
);
  logic [1:0] tick_q;
  logic [4:0] src0_q [0:7];

  // slow mode takes one cycle in three, so the buffers see a stalling far end
  assign tx_ready = (slow && tick_q != 2'h0) ? 3'h0 : ~hold;

  // log popped posted tags; flag any non-posted packet seen in a posted-only set
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      tick_q <= 2'h0;
      pops0  <= 8'h00;
      bad    <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
      if (tx_valid[0] && tx_ready[0])
      begin
        src0_q[pops0[2:0]] <= tx_data[0].source_tag_field;
        pops0              <= pops0 + 8'h01;
      end
      for (int c = 0; c < 3; c++)
        if (tx_valid[c] && tx_ready[c] && tx_data[c].cls != LVCS_CLS_POSTED &&
            (tx_data[c].set == LVCS_SET_UNFLOWED || tx_data[c].set == LVCS_SET_STREAM))
          bad <= 1'b1;
    end
  end
endmodule : lvcs_sink
`default_nettype wire

//--- verif/lvcs_router_tb.sv
// self-checking bench of the channel-set router: register tasks, packet tasks, sink model
// assumes: lvcs_pkg compiled first, lvcs_defines.svh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "lvcs_defines.svh"

module lvcs_router_tb
  import lvcs_pkg::*;
;
  logic            clock;
  logic            reset;
  logic            ce;
  lvcs_reg_req_t   reg_req;
  logic [31:0]     reg_rdata;
  logic            rx_valid;
  lvcs_pkt_t       rx_pkt;
  logic [2:0]      rx_ready;
  logic [2:0]      tx_valid;
  lvcs_fwd_t [2:0] tx_data;
  logic [2:0]      tx_ready;
  logic            side0_legacy;
  logic            side1_legacy;
  logic            dropped_flag;
  logic            illegal_flag;
  logic [2:0]      hold;
  logic            slow;
  logic [7:0]      pops0;
  logic            bad;
  int              n_fail;
  int              check_count;
  int              cycles;
  int              p0;
  logic [2:0]      hmask [0:2] = '{3'h7, 3'h3, 3'h6};
  logic [2:0]      rexp [0:2]  = '{3'h0, 3'h6, 3'h5};
  logic [3:0]      rsv [0:2]   = '{4'h8, 4'h9, 4'hC};

  // stream count cut to 6 so that channel numbers 6..15 hit the refusal path
  lvcs_router #(.CHANNEL_SET_SUPPORT(8'h07), .STREAM_COUNT(5'h06)) u_lvcs_router (
    .clock(clock), .reset(reset), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_pkt(rx_pkt), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .side0_legacy(side0_legacy),
    .side1_legacy(side1_legacy), .dropped_flag(dropped_flag), .illegal_flag(illegal_flag));

  lvcs_sink u_lvcs_sink (
    .clock(clock), .reset(reset), .tx_valid(tx_valid), .tx_data(tx_data), .hold(hold),
    .slow(slow), .tx_ready(tx_ready), .pops0(pops0), .bad(bad));

  always #4 clock = ~clock;

  task automatic final_report();
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // a hang ends as a mismatch in the same closing report
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic lvcs_pkt_t mk(logic sd, lvcs_class_t c, logic iso, logic [3:0] t, logic [4:0] s,
                                   logic [2:0] r);
    mk = '{side: sd, cls: c, isoc: iso, sequence_tag: t, source_tag_field: s, response_set_field: r,
           pass_posted_write_flag: s[0]};
  endfunction : mk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask : rd

  task automatic send(input lvcs_pkt_t p);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_pkt   <= p;
    @(posedge clock);
    rx_valid <= 1'b0;
    #1;
  endtask : send

  // one packet through an empty buffer, head compared, then popped by the sink
  task automatic fwd(input lvcs_pkt_t p, input int c, input lvcs_set_t s, input logic [3:0] ch,
                     input logic eoc, input logic [3:0] seq, input logic ck);
    send(p);
    chk("tx_valid", 32'(1 << c), 32'(tx_valid));
    chk("set", 32'(s), 32'(tx_data[c].set));
    chk("end_of_chain", 32'(eoc), 32'(tx_data[c].end_of_chain));
    chk("out_side", 32'(!p.side), 32'(tx_data[c].out_side));
    chk("pass_flag", 32'(p.pass_posted_write_flag), 32'(tx_data[c].pass_posted_write_flag));
    if (s == LVCS_SET_STREAM)
      chk("channel", 32'(ch), 32'(tx_data[c].channel));
    if (ck)
      chk("sequence_tag", 32'(seq), 32'(tx_data[c].sequence_tag));
    @(posedge clock);
    hold <= 3'h0;
    @(posedge clock);
    hold <= 3'h7;
  endtask : fwd

  // refused packet: flag raised, nothing forwarded, status bit cleared by writing one
  task automatic bad_pkt(input lvcs_pkt_t p);
    send(p);
    repeat (2) @(posedge clock);
    #1;
    chk("illegal_flag", 32'h0000_0001, 32'(illegal_flag));
    chk("tx_valid", 32'h0000_0000, 32'(tx_valid));
    rd(`LVCS_ADDR_STATUS, 32'h0000_0002, "status");
    wr(`LVCS_ADDR_STATUS, 32'h0000_0002);
    rd(`LVCS_ADDR_STATUS, 32'h0000_0000, "status");
  endtask : bad_pkt

  initial
  begin
    clock = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    reg_req = '0;
    rx_valid = 1'b0;
    rx_pkt = '0;
    hold = 3'h7;
    slow = 1'b0;
    n_fail = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    // reset state, caps, unmapped place, non-host acceptance with the far end stalled
    chk("side0_legacy", 32'h0000_0001, 32'(side0_legacy));
    chk("side1_legacy", 32'h0000_0001, 32'(side1_legacy));
    chk("rx_ready", 32'h0000_0007, 32'(rx_ready));
    rd(`LVCS_ADDR_EN_SIDE0, 32'h0000_0000, "side0_enables");
    rd(`LVCS_ADDR_EN_SIDE1, 32'h0000_0000, "side1_enables");
    rd(`LVCS_ADDR_CAPS, 32'h0000_0607, "caps");
    rd(8'h20, 32'h0000_0000, "unmapped");
    fwd(mk(1'b0, LVCS_CLS_POSTED, 1'b0, 4'h0, 5'h03, 3'h0), 0, LVCS_SET_BASE, 4'h0, 1'b0, 4'h0, 1'b0);
    fwd(mk(1'b1, LVCS_CLS_RESPONSE, 1'b0, 4'h0, 5'h00, 3'h0), 2, LVCS_SET_BASE, 4'h0, 1'b0, 4'h0, 1'b0);
    // enable sets; bits of unsupported sets read back as clear
    wr(`LVCS_ADDR_EN_SIDE0, 32'h0000_00FF);
    wr(`LVCS_ADDR_EN_SIDE1, 32'h0000_0005);
    rd(`LVCS_ADDR_EN_SIDE0, 32'h0000_0007, "side0_enables");
    chk("side0_legacy", 32'h0000_0000, 32'(side0_legacy));
    chk("side1_legacy", 32'h0000_0000, 32'(side1_legacy));
    fwd(mk(1'b0, LVCS_CLS_POSTED, 1'b1, 4'hE, 5'h05, 3'h0), 0, LVCS_SET_STREAM, 4'h5, 1'b0, 4'h0, 1'b1);
    fwd(mk(1'b0, LVCS_CLS_POSTED, 1'b1, 4'hD, 5'h00, 3'h0), 0, LVCS_SET_UNFLOWED, 4'h0, 1'b1, 4'h0, 1'b1);
    fwd(mk(1'b1, LVCS_CLS_NONPOSTED, 1'b1, 4'h3, 5'h00, 3'h0), 1, LVCS_SET_ALT, 4'h0, 1'b0, 4'h3, 1'b1);
    fwd(mk(1'b1, LVCS_CLS_RESPONSE, 1'b1, 4'h0, 5'h00, 3'h0), 2, LVCS_SET_ALT, 4'h0, 1'b0, 4'h0, 1'b0);
    bad_pkt(mk(1'b0, LVCS_CLS_NONPOSTED, 1'b1, 4'hD, 5'h00, 3'h0));
    bad_pkt(mk(1'b0, LVCS_CLS_RESPONSE, 1'b1, 4'h0, 5'h00, 3'h2));
    bad_pkt(mk(1'b0, LVCS_CLS_POSTED, 1'b1, 4'hF, 5'h01, 3'h0));
    for (int i = 0; i < 3; i++)
      bad_pkt(mk(1'b0, LVCS_CLS_POSTED, 1'b1, rsv[i], 5'h00, 3'h0));
    // side0 back to legacy: its isoc traffic moves to the alternate set with the tag remapped
    wr(`LVCS_ADDR_EN_SIDE0, 32'h0000_0000);
    rd(`LVCS_ADDR_EN_SIDE0, 32'h0000_0000, "side0_enables");
    chk("side0_legacy", 32'h0000_0001, 32'(side0_legacy));
    fwd(mk(1'b0, LVCS_CLS_POSTED, 1'b1, 4'h8, 5'h00, 3'h0), 0, LVCS_SET_ALT, 4'h0, 1'b0, 4'h1, 1'b1);
    fwd(mk(1'b0, LVCS_CLS_POSTED, 1'b1, 4'hB, 5'h00, 3'h0), 0, LVCS_SET_ALT, 4'h0, 1'b0, 4'h3, 1'b1);
    wr(`LVCS_ADDR_CTRL, 32'h0000_0008);
    fwd(mk(1'b0, LVCS_CLS_POSTED, 1'b1, 4'hE, 5'h05, 3'h0), 0, LVCS_SET_ISOC, 4'h0, 1'b0, 4'h0, 1'b0);
    wr(`LVCS_ADDR_CTRL, 32'h0000_0000);
    // fill the posted buffer: other classes still accept, unflowed overflow is dropped
    p0 = int'(pops0);
    for (int i = 0; i < 4; i++)
      send(mk(1'b0, LVCS_CLS_POSTED, 1'b0, 4'h0, 5'(i), 3'h0));
    @(posedge clock);
    #1;
    chk("rx_ready", 32'h0000_0006, 32'(rx_ready));
    send(mk(1'b1, LVCS_CLS_POSTED, 1'b1, 4'hD, 5'h00, 3'h0));
    chk("dropped_flag", 32'h0000_0001, 32'(dropped_flag));
    rd(`LVCS_ADDR_STATUS, 32'h0000_0001, "status");
    send(mk(1'b0, LVCS_CLS_NONPOSTED, 1'b0, 4'h0, 5'h00, 3'h0));
    chk("tx_valid", 32'h0000_0003, 32'(tx_valid));
    @(posedge clock);
    hold <= 3'h0;
    slow <= 1'b1;
    for (int k = 0; k < 60 && int'(pops0) != p0 + 4; k++)
      @(posedge clock);
    for (int i = 0; i < 4; i++)
      chk("pop_order", 32'(i), 32'(u_lvcs_sink.src0_q[3'(p0 + i)]));
    @(posedge clock);
    slow <= 1'b0;
    hold <= 3'h7;
    // host couplings: each class acceptance follows only its allowed outgoing classes
    wr(`LVCS_ADDR_CTRL, 32'h0000_0005);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock);
      hold <= hmask[i];
      repeat (3) @(posedge clock);
      #1;
      chk("host_rx_ready", 32'(rexp[i]), 32'(rx_ready));
    end
    @(posedge clock);
    hold <= 3'h3;
    send(mk(1'b0, LVCS_CLS_NONPOSTED, 1'b0, 4'h0, 5'h00, 3'h0));
    chk("reflect", 32'h0000_0001, 32'(tx_data[1].reflect));
    @(posedge clock);
    hold <= 3'h0;
    repeat (3) @(posedge clock);
    #1;
    chk("sink_bad", 32'h0000_0000, 32'(bad));
    // clock enable low: a presented packet is neither taken nor forwarded
    @(posedge clock);
    ce <= 1'b0;
    send(mk(1'b0, LVCS_CLS_POSTED, 1'b0, 4'h0, 5'h00, 3'h0));
    chk("ce_freeze", 32'h0000_0000, 32'(tx_valid));
    @(posedge clock);
    ce <= 1'b1;
    final_report();
  end
endmodule : lvcs_router_tb
`default_nettype wire
